/* File: src/motor_if_regs.vh */
// Constants for the motor control pin interface
// Behaviour
// - Brake pin high enters and holds brake; leave only once pin low.
// - Brake style picked by setting: low-side brake or align brake.
// - Ramp speed down to brake entry threshold before braking.
// - Host brake override over serial bus replaces brake pin.
// - Direction high gives A-B-C order; low gives A-C-B order.
// - Host direction override over serial bus replaces direction pin.
// - Drive-disable high turns off all six bridge switches, coasting; code still drives one step for a clock when waking from sleep with it high.
// - Drive-disable release reruns the full restart sequence.
// - Drive-disable never causes sleep; only speed/wake pin does.
// - Speed/wake pin gives speed command and controls sleep and standby.
// - Speed/wake source selectable: PWM input or analog voltage.
// - Each monitor output shows its pointed variable, refreshed per PWM cycle.
// - Speed pulse output rate proportional to rotor speed.
// - Any fault pulls active-low fault pin; details kept readable.
// - Host writes stored configuration and reads fault and motor state.
// - Serial clock is input only; serial data is bidirectional.
// - Bridge supports continuous full duty, high side held on.
// - Optional external clock reference accepted as timing source.
// - Stored configuration applied at start-up for stand-alone running.
// - Speed input type 0 means analog voltage speed command.
// - Speed input type 1 means PWM, speed follows duty cycle.
`ifndef MOTOR_IF_REGS_VH
`define MOTOR_IF_REGS_VH
`define SPD_TYPE_ANALOG    1'b0
`define SPD_TYPE_PWM       1'b1
`define BRK_MODE_LOWSIDE   1'b0
`define BRK_MODE_ALIGN     1'b1
`define ST_SLEEP           3'h0
`define ST_START           3'h1
`define ST_RUN             3'h2
`define ST_RAMP            3'h3
`define ST_BRAKE           3'h4
`define ST_COAST           3'h5
`define PWM_PERIOD         8'hFF
`define START_CYCLES       8'h40
`define VAR_COUNT          4
`endif

/* File: src/pwm_duty_meter.v */
// Measures the duty of a PWM input over a fixed period window
`timescale 1ns/100ps
`include "motor_if_regs.vh"
module pwm_duty_meter (
    input  wire       clk_sys_i,   // System clock
    input  wire       rst_n_i,     // Async reset, active low
    input  wire       ce_i,        // Clock enable
    input  wire       pwm_i,       // PWM level
    input  wire       tick_i,      // Window end
    output reg  [7:0] duty_o       // Duty of last window
);
    reg [7:0] hi_cnt_r;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_cnt_r <= 8'h00;
            duty_o   <= 8'h00;
        end else if (ce_i) begin
            if (tick_i) begin
                duty_o   <= hi_cnt_r;
                hi_cnt_r <= {7'h00, pwm_i};
            end else if (pwm_i && hi_cnt_r != 8'hFF) begin
                hi_cnt_r <= hi_cnt_r + 8'h01;
            end
        end
    end
endmodule

/* File: src/motor_control_pin_interface.v */
// Pin interface and control sequencer of the motor driver
`timescale 1ns/100ps
`include "motor_if_regs.vh"
module motor_control_pin_interface (
    input  wire       clk_sys_i,                  // System clock 20 MHz
    input  wire       rst_n_i,                    // Async reset, active low
    input  wire       ce_i,                       // Clock enable
    input  wire       reference_clock_input_i,    // External clock reference level
    input  wire       ref_clk_sel_i,              // Use external reference for PWM timing
    input  wire       brake_pin_i,                // Brake pin
    input  wire       dir_pin_i,                  // Direction pin
    input  wire       drive_disable_pin_i,        // Drive-disable pin
    input  wire       speed_wake_pin_i,           // Speed/wake PWM level
    input  wire [7:0] speed_analog_i,             // Digitised analog speed voltage
    input  wire       speed_input_type_select_i,  // 0 analog, 1 PWM
    input  wire       brake_pin_mode_i,           // 0 low-side, 1 align
    input  wire [7:0] brake_speed_threshold_i,    // Brake entry speed
    input  wire       brake_ovr_en_i,             // Brake override enable
    input  wire       brake_ovr_i,                // Brake override level
    input  wire       dir_ovr_en_i,               // Direction override enable
    input  wire       dir_ovr_i,                  // Direction override level
    input  wire [1:0] monitor_a_variable_pointer_i, // Monitor A select
    input  wire [1:0] monitor_b_variable_pointer_i, // Monitor B select
    input  wire       nv_cfg_valid_i,             // Stored configuration loaded
    input  wire [7:0] fault_flags_i,              // Raw fault sources
    input  wire       fault_clr_i,                // Clear latched faults
    input  wire       scl_i,                      // Serial clock input
    input  wire       sda_i,                      // Serial data in
    input  wire       sda_drive_low_i,            // Serial core wants data low
    output wire       sda_o,                      // Serial data out
    output wire       sda_oe_o,                   // Serial data enable
    output reg  [5:0] gate_o,                     // AH AL BH BL CH CL
    output reg  [7:0] monitor_analog_out_a_o,     // Monitor A value
    output reg  [7:0] monitor_analog_out_b_o,     // Monitor B value
    output reg        speed_pulse_output_o,       // Speed pulses
    output reg        fault_indicator_n_o,        // Fault, active low
    output reg  [7:0] fault_status_o,             // Latched fault detail
    output reg  [2:0] motor_state_o,              // Sequencer state
    output reg  [7:0] speed_o,                    // Present speed
    output reg        sleep_o                     // Sleep requested
);
    // ********************************************************
    // Input sampling and overrides
    // ********************************************************
    reg brake_r;
    reg dir_r;
    reg drive_disable_pin_r;
    reg ref_d_r;
    reg ref_q_r;
    reg ref_p_r;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            brake_r  <= 1'b0;
            dir_r    <= 1'b0;
            drive_disable_pin_r <= 1'b0;
            ref_d_r  <= 1'b0;
            ref_q_r  <= 1'b0;
            ref_p_r  <= 1'b0;
        end else if (ce_i) begin
            brake_r  <= brake_pin_i;
            dir_r    <= dir_pin_i;
            drive_disable_pin_r <= drive_disable_pin_i;
            ref_d_r  <= reference_clock_input_i;
            ref_q_r  <= ref_d_r;
            ref_p_r  <= ref_q_r;
        end
    end
    wire brake_eff = brake_ovr_en_i ? brake_ovr_i : brake_r;
    wire dir_eff   = dir_ovr_en_i ? dir_ovr_i : dir_r;
    // SCL is only ever read by the serial core
    assign sda_o    = 1'b0;
    assign sda_oe_o = sda_drive_low_i;
    // ********************************************************
    // PWM timebase, internal or external reference
    // ********************************************************
    // Edge taken behind the second stage only
    wire       ref_edge = ref_q_r & ~ref_p_r;
    wire       adv      = ref_clk_sel_i ? ref_edge : 1'b1;
    reg  [7:0] pwm_cnt_r;
    wire       pwm_tick = adv && (pwm_cnt_r == `PWM_PERIOD);
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            pwm_cnt_r <= 8'h00;
        else if (ce_i && adv)
            pwm_cnt_r <= pwm_tick ? 8'h00 : pwm_cnt_r + 8'h01;
    end
    // ********************************************************
    // Speed command
    // ********************************************************
    wire [7:0] pwm_duty;
    pwm_duty_meter u_meter (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .pwm_i     (speed_wake_pin_i),
        .tick_i    (pwm_tick),
        .duty_o    (pwm_duty)
    );
    wire [7:0] speed_cmd = (speed_input_type_select_i == `SPD_TYPE_PWM) ?
                           pwm_duty : speed_analog_i;
    wire       wake      = (speed_cmd != 8'h00);
    // ********************************************************
    // Sequencer
    // ********************************************************
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [7:0] speed_nxt;
    reg [7:0] start_cnt_r;
    reg       drive_disable_pin_q_r;
    reg [1:0] step_r;
    always @* begin
        state_nxt = state_r;
        speed_nxt = speed_o;
        case (state_r)
            `ST_SLEEP: begin
                speed_nxt = 8'h00;
                if (wake && nv_cfg_valid_i)
                    state_nxt = `ST_START;
            end
            `ST_START: begin
                if (start_cnt_r == `START_CYCLES)
                    state_nxt = `ST_RUN;
            end
            `ST_RUN: begin
                if (brake_eff)
                    state_nxt = `ST_RAMP;
                else if (!wake)
                    state_nxt = `ST_SLEEP;
                else if (pwm_tick && speed_o < speed_cmd)
                    speed_nxt = speed_o + 8'h01;
                else if (pwm_tick && speed_o > speed_cmd)
                    speed_nxt = speed_o - 8'h01;
            end
            `ST_RAMP: begin
                if (!brake_eff)
                    state_nxt = `ST_RUN;
                else if (speed_o <= brake_speed_threshold_i)
                    state_nxt = `ST_BRAKE;
                else if (pwm_tick)
                    speed_nxt = speed_o - 8'h01;
            end
            `ST_BRAKE: begin
                speed_nxt = 8'h00;
                if (!brake_eff)
                    state_nxt = `ST_START;
            end
            `ST_COAST: state_nxt = `ST_COAST;
            default: state_nxt = `ST_SLEEP;
        endcase
        // Coast overrides all motion, but never sleep
        if (drive_disable_pin_r && state_r != `ST_SLEEP) begin
            state_nxt = `ST_COAST;
            speed_nxt = 8'h00;
        end else if (state_r == `ST_COAST && !drive_disable_pin_r)
            state_nxt = `ST_START;
    end
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r     <= `ST_SLEEP;
            speed_o     <= 8'h00;
            start_cnt_r <= 8'h00;
            drive_disable_pin_q_r  <= 1'b0;
            step_r      <= 2'h0;
        end else if (ce_i) begin
            state_r    <= state_nxt;
            speed_o    <= speed_nxt;
            drive_disable_pin_q_r <= drive_disable_pin_r;
            if (state_r != `ST_START)
                start_cnt_r <= 8'h00;
            else if (start_cnt_r != `START_CYCLES)
                start_cnt_r <= start_cnt_r + 8'h01;
            if (state_r == `ST_START && start_cnt_r == `START_CYCLES)
                speed_o <= 8'h01;
            if (pwm_tick && (state_r == `ST_RUN || state_r == `ST_RAMP
                             || state_r == `ST_START)) begin
                if (dir_eff)
                    step_r <= (step_r == 2'h2) ? 2'h0 : step_r + 2'h1;
                else
                    step_r <= (step_r == 2'h0) ? 2'h2 : step_r - 2'h1;
            end
        end
    end
    // ********************************************************
    // Gate drive
    // ********************************************************
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_o        <= 6'h00;
            motor_state_o <= `ST_SLEEP;
            sleep_o       <= 1'b1;
        end else if (ce_i) begin
            motor_state_o <= state_r;
            sleep_o       <= (state_r == `ST_SLEEP);
            case (state_r)
                `ST_COAST: gate_o <= 6'h00;
                `ST_SLEEP: gate_o <= 6'h00;
                `ST_BRAKE: begin
                    if (brake_pin_mode_i == `BRK_MODE_ALIGN)
                        gate_o <= 6'h25;   // AH, BL, CL
                    else
                        gate_o <= 6'h15;   // All low sides
                end
                default: begin
                    // Held high side stays on for whole step, full duty
                    case (step_r)
                        2'h0:    gate_o <= 6'h24;  // A high, B low
                        2'h1:    gate_o <= 6'h09;  // B high, C low
                        default: gate_o <= 6'h12;  // C high, A low
                    endcase
                end
            endcase
        end
    end
    // ********************************************************
    // Speed pulses, monitors and faults
    // ********************************************************
    reg [15:0] fg_acc_r;
    reg [7:0]  mon_var [0:`VAR_COUNT-1];
    always @* begin
        mon_var[0] = speed_o;
        mon_var[1] = speed_cmd;
        mon_var[2] = {5'h00, state_r};
        mon_var[3] = pwm_duty;
    end
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fg_acc_r               <= 16'h0000;
            speed_pulse_output_o   <= 1'b0;
            monitor_analog_out_a_o <= 8'h00;
            monitor_analog_out_b_o <= 8'h00;
            fault_status_o         <= 8'h00;
            fault_indicator_n_o    <= 1'b1;
        end else if (ce_i) begin
            // Accumulator overflow rate scales with speed
            {speed_pulse_output_o, fg_acc_r} <=
                {1'b0, fg_acc_r} + {9'h000, speed_o};
            if (pwm_tick) begin
                monitor_analog_out_a_o <= mon_var[monitor_a_variable_pointer_i];
                monitor_analog_out_b_o <= mon_var[monitor_b_variable_pointer_i];
            end
            // New fault wins over clear
            fault_status_o <= (fault_clr_i ? 8'h00 : fault_status_o)
                              | fault_flags_i;
            fault_indicator_n_o <= ~(|fault_flags_i |
                                     (|fault_status_o & ~fault_clr_i));
        end
    end
endmodule

/* File: testbench/motor_if_assertions.sv */
// Checker of the motor pin interface outputs
`timescale 1ns/100ps
`include "motor_if_regs.vh"
module motor_if_checker (
    input wire       clk_sys_i,            // Clock
    input wire       rst_n_i,              // Reset
    input wire       ce_i,                 // Enable
    input wire       drive_disable_pin_i,  // Disable pin
    input wire       brake_pin_mode_i,     // Brake style
    input wire       nv_cfg_valid_i,       // Config loaded
    input wire [7:0] fault_flags_i,        // Fault sources
    input wire       fault_clr_i,          // Fault clear
    input wire       sda_drive_low_i,      // Data low
    input wire       sda_o,                // Data out
    input wire       sda_oe_o,             // Data enable
    input wire [5:0] gate_o,               // Gates
    input wire       fault_indicator_n_o,  // Fault pin
    input wire [7:0] fault_status_o,       // Fault detail
    input wire [2:0] motor_state_o,        // State
    input wire       sleep_o               // Sleep
);
    reg [7:0] start_cnt_r;
    // Cycles spent in start
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            start_cnt_r <= 8'h00;
        else
            start_cnt_r <= (motor_state_o == `ST_START) ? start_cnt_r + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_sda; sda_oe_o == sda_drive_low_i && sda_o == 1'b0; endproperty
    a_sda: assert property (p_sda) else $error("data drive wrong");
    property p_coast;
        motor_state_o == `ST_COAST && $past(motor_state_o) == `ST_COAST |-> gate_o == 6'h00 && !sleep_o;
    endproperty
    a_coast: assert property (p_coast) else $error("coast drive wrong");
    property p_dis;
        $rose(drive_disable_pin_i) && ce_i && motor_state_o != `ST_SLEEP |-> ##[1:4] motor_state_o == `ST_COAST;
    endproperty
    a_dis: assert property (p_dis) else $error("no coast");
    property p_brake;
        (motor_state_o == `ST_BRAKE) [*2] |-> gate_o == (brake_pin_mode_i ? 6'h25 : 6'h15);
    endproperty
    a_brake: assert property (p_brake) else $error("brake style wrong");
    property p_fset;
        ce_i && fault_flags_i != 8'h00 |=> !fault_indicator_n_o && (fault_status_o & $past(fault_flags_i)) == $past(fault_flags_i);
    endproperty
    a_fset: assert property (p_fset) else $error("fault not shown");
    property p_fkeep;
        ce_i && !fault_clr_i |=> (fault_status_o & $past(fault_status_o)) == $past(fault_status_o);
    endproperty
    a_fkeep: assert property (p_fkeep) else $error("fault lost");
    property p_fclr; ce_i && fault_clr_i && fault_flags_i == 8'h00 |=> fault_status_o == 8'h00; endproperty
    a_fclr: assert property (p_fclr) else $error("fault not cleared");
    property p_start;
        $past(motor_state_o) == `ST_START && motor_state_o == `ST_RUN |-> start_cnt_r >= 8'h3E && start_cnt_r <= 8'h42;
    endproperty
    a_start: assert property (p_start) else $error("start length wrong");
    property p_nocfg;
        (!nv_cfg_valid_i && motor_state_o == `ST_SLEEP) [*4] |=> motor_state_o == `ST_SLEEP;
    endproperty
    a_nocfg: assert property (p_nocfg) else $error("woke unconfigured");
    c_brake: cover property (motor_state_o == `ST_BRAKE);
    c_coast: cover property (motor_state_o == `ST_COAST);
    c_fault: cover property (!fault_indicator_n_o);
endmodule

/* File: testbench/host_pin_model.sv */
// Host side: speed PWM source and serial bus lines
`timescale 1ns/100ps
module host_pin_model (
    input  wire       clk_sys_i,    // Clock
    input  wire [7:0] duty_i,       // High clocks per period
    input  wire       sda_oe_i,     // Device pulls data low
    output reg        speed_wake_o, // Speed/wake level
    output wire       scl_o,        // Serial clock, idle
    output wire       sda_o         // Resolved data line
);
    reg [7:0] phase_r = 8'h00;
    initial speed_wake_o = 1'b0;
    always @(posedge clk_sys_i) begin
        phase_r <= phase_r + 8'h01;
        speed_wake_o <= #1 (phase_r < duty_i);
    end
    assign scl_o = 1'b1;
    assign sda_o = sda_oe_i ? 1'b0 : 1'b1;
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench of the motor pin interface
`timescale 1ns/100ps
`include "motor_if_regs.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module tb_top;
    reg        clk_sys_i = 1'b0;
    reg        rst_n_i = 1'b0;
    reg        rclk = 1'b0, rsel = 1'b0, brake = 1'b0, dir = 1'b1, dis = 1'b0, nv = 1'b0;
    reg        stype = 1'b0, bmode = 1'b0, b_en = 1'b0, b_ovr = 1'b0, d_en = 1'b0;
    reg        d_ovr = 1'b0, f_clr = 1'b0, sda_low = 1'b0;
    reg  [7:0] analog = 8'h00, thr = 8'h00, duty = 8'h37, flags = 8'h00, fm = 8'h00;
    reg  [1:0] ptr_a = 2'h0, ptr_b = 2'h0;
    reg  [2:0] hs, prev;
    wire       sw, scl, sda, sda_o, sda_oe, fault_n, sleep, fg;
    wire [5:0] gate;
    wire [7:0] mon_a, mon_b, fstat, speed;
    wire [2:0] state;
    integer    num_errors = 0, checked = 0, seed = 36369, i, k, c, n;
    initial forever #25 clk_sys_i = ~clk_sys_i;
    initial forever #37 rclk = ~rclk;
    motor_control_pin_interface motor_control_pin_interface_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .reference_clock_input_i(rclk),
        .ref_clk_sel_i(rsel), .brake_pin_i(brake), .dir_pin_i(dir), .drive_disable_pin_i(dis),
        .speed_wake_pin_i(sw), .speed_analog_i(analog), .speed_input_type_select_i(stype),
        .brake_pin_mode_i(bmode), .brake_speed_threshold_i(thr), .brake_ovr_en_i(b_en),
        .brake_ovr_i(b_ovr), .dir_ovr_en_i(d_en), .dir_ovr_i(d_ovr),
        .monitor_a_variable_pointer_i(ptr_a), .monitor_b_variable_pointer_i(ptr_b),
        .nv_cfg_valid_i(nv), .fault_flags_i(flags), .fault_clr_i(f_clr), .scl_i(scl),
        .sda_i(sda), .sda_drive_low_i(sda_low), .sda_o(sda_o), .sda_oe_o(sda_oe), .gate_o(gate),
        .monitor_analog_out_a_o(mon_a), .monitor_analog_out_b_o(mon_b),
        .speed_pulse_output_o(fg), .fault_indicator_n_o(fault_n), .fault_status_o(fstat),
        .motor_state_o(state), .speed_o(speed), .sleep_o(sleep));
    host_pin_model host_pin_model_inst (.clk_sys_i(clk_sys_i), .duty_i(duty),
        .sda_oe_i(sda_oe), .speed_wake_o(sw), .scl_o(scl), .sda_o(sda));
    task summarize;
        begin
            if (num_errors == 0 && checked > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task tick(input integer m);
        begin
            repeat (m) @(posedge clk_sys_i);
            #1;
        end
    endtask
    task wait_for(input [7:0] v, input integer lim);
        begin
            c = 0;
            while ({5'h00, state} !== v && c < lim) begin
                tick(1);
                c++;
            end
            if (c >= lim) begin
                num_errors++;
                $display("ERROR state wait expected %0h seen %0h", v, state);
                summarize;
            end
        end
    endtask
    // Later phase steps must follow the effective direction
    task spin(input d);
        for (k = 0; k < 3; k++) begin
            c = 0;
            hs = {gate[5], gate[3], gate[1]};
            while ({gate[5], gate[3], gate[1]} === hs && c < 2000) begin
                tick(1);
                c++;
            end
            if (k > 0)
                `CHK("phase", d ? {prev[0], prev[2:1]} : {prev[1:0], prev[2]}, hs ^ hs ^ {gate[5], gate[3], gate[1]})
            prev = {gate[5], gate[3], gate[1]};
        end
    endtask
    function [7:0] mon_exp(input [1:0] p);
        mon_exp = (p == 2'h2) ? 8'h02 : (p == 2'h3) ? duty : 8'h20;
    endfunction
    initial begin
        tick(3);
        rst_n_i = 1'b1;
        `CHK("reset state", `ST_SLEEP, state)
        analog = 8'h20;
        tick(20);
        `CHK("no config", `ST_SLEEP, state)
        nv = 1'b1;
        wait_for(`ST_START, 20);
        wait_for(`ST_RUN, 100);
        tick(8400);
        `CHK("analog speed", 8'h20, speed)
        for (i = 0; i < 4; i++) begin
            dir = i[0];
            d_en = i[1];
            d_ovr = ~i[0];
            rsel = (i == 3);
            spin(d_en ? d_ovr : dir);
        end
        d_en = 1'b0;
        rsel = 1'b0;
        for (i = 0; i < 4; i++) begin
            ptr_a = i[1:0];
            ptr_b = 2'h3 - i[1:0];
            tick(600);
            `CHK("monitor a", mon_exp(ptr_a), mon_a)
            `CHK("monitor b", mon_exp(ptr_b), mon_b)
        end
        // Speed 0x20 steady: 8192 cycles carry exactly four wraps
        n = 0;
        for (k = 0; k < 8192; k++) begin
            tick(1);
            n = n + fg;
        end
        `CHK("speed pulses", 4, n)
        thr = 8'h1C;
        brake = 1'b1;
        wait_for(`ST_RAMP, 10);
        c = 0;
        while (speed > 8'h1C && c < 1500) begin
            tick(1);
            c++;
        end
        `CHK("brake entry", 8'h1C, speed)
        wait_for(`ST_BRAKE, 6);
        tick(40);
        `CHK("brake low side", 6'h15, gate)
        brake = 1'b0;
        wait_for(`ST_START, 10);
        bmode = 1'b1;
        thr = 8'hFF;
        wait_for(`ST_RUN, 100);
        b_en = 1'b1;
        b_ovr = 1'b1;
        wait_for(`ST_BRAKE, 20);
        tick(2);
        `CHK("brake align", 6'h25, gate)
        b_ovr = 1'b0;
        wait_for(`ST_START, 10);
        b_en = 1'b0;
        b_ovr = 1'b1;
        wait_for(`ST_RUN, 100);
        dis = 1'b1;
        wait_for(`ST_COAST, 6);
        tick(2);
        `CHK("coast gates", 6'h00, gate)
        `CHK("coast awake", 1'b0, sleep)
        dis = 1'b0;
        wait_for(`ST_START, 6);
        stype = 1'b1;
        duty = 8'h00;
        wait_for(`ST_SLEEP, 1500);
        dis = 1'b1;
        tick(20);
        `CHK("disable in sleep", `ST_SLEEP, state)
        dis = 1'b0;
        duty = 8'h40;
        wait_for(`ST_START, 1500);
        ptr_a = 2'h1;
        tick(600);
        `CHK("pwm command", 8'h40, mon_a)
        for (i = 0; i < 60; i++) begin
            n = $random(seed);
            flags = n[3] ? 8'h00 : (n[15:8] & n[23:16]);
            f_clr = n[4];
            sda_low = n[5];
            tick(1);
            fm = (f_clr ? 8'h00 : fm) | flags;
            `CHK("fault detail", fm, fstat)
            `CHK("fault pin", fm == 8'h00, fault_n)
            `CHK("data line", ~sda_low, sda)
        end
        rst_n_i = 1'b0;
        tick(1);
        `CHK("fault reset", 8'h00, fstat)
        rst_n_i = 1'b1;
        tick(2);
        summarize;
    end
endmodule
bind motor_control_pin_interface motor_if_checker motor_if_checker_inst (.clk_sys_i, .rst_n_i,
    .ce_i, .drive_disable_pin_i, .brake_pin_mode_i, .nv_cfg_valid_i, .fault_flags_i, .fault_clr_i,
    .sda_drive_low_i, .sda_o, .sda_oe_o, .gate_o, .fault_indicator_n_o, .fault_status_o,
    .motor_state_o, .sleep_o);
